// file: core/iaae_pkg.sv
// package of encodings, field positions and types for the integer add/abs execute block
// What this block does
// - top instruction bit picks 32-bit (clear) or 64-bit (set) operation
// - absolute value: signed magnitude of source, low datasize bits written, flags kept
// - absolute value encoding undefined unless compact integer feature is present
// - destination, first and second source numbers come from their own fields
// - add with carry: sum of sources plus carry flag, flags unchanged
// - flag-setting add with carry: same sum, flags replaced from addition
// - extended add: extend second source, shift left by amount, add to first
// - extended add undefined when shift amount exceeds four
// - extend codes 0-3 zero-extend, 4-7 sign-extend byte, half, word, double
// - extended add reads second operand as byte, half, word or double
// - 64-bit extended add reads full source only when low extend bits both set
// - extended add: register 31 as destination or first source is stack pointer
// - extended add: register 31 as second source reads as zero
// - execution time independent of data and flags; abs when timing bit set
// - exception response independent of data and flag values
// - 32-bit forms ignore upper source halves and zero upper destination half
// - 32-bit flag-setting forms derive flags from low 32 bits only
package iaae_pkg;
    localparam int IAAE_XLEN = 64;
    localparam int IAAE_WIDTH_BIT = 31;
    localparam int IAAE_RD_LO = 0;
    localparam int IAAE_RN_LO = 5;
    localparam int IAAE_RM_LO = 16;
    localparam int IAAE_AMT_LO = 10;
    localparam int IAAE_OPT_LO = 13;
    localparam logic [4:0] IAAE_REG31 = 5'h1f;
    localparam logic [2:0] IAAE_MAX_SHIFT = 3'h4;
    // opcode patterns with the width bit and register fields cleared
    localparam logic [31:0] IAAE_ABS_MASK = 32'h7ffffc00;
    localparam logic [31:0] IAAE_ABS_VAL = 32'h5ac02000;
    localparam logic [31:0] IAAE_ADC_MASK = 32'h7fe0fc00;
    localparam logic [31:0] IAAE_ADC_VAL = 32'h1a000000;
    localparam logic [31:0] IAAE_ADD_CARRY_FLAGS_OP_VAL = 32'h3a000000;
    localparam logic [31:0] IAAE_ADDX_MASK = 32'h7fe00000;
    localparam logic [31:0] IAAE_ADDX_VAL = 32'h0b200000;

    typedef enum logic [2:0] {
        zero_extend_byte = 3'b000,
        zero_extend_half = 3'b001,
        zero_extend_word = 3'b010,
        zero_extend_double = 3'b011,
        sign_extend_byte = 3'b100,
        sign_extend_half = 3'b101,
        sign_extend_word = 3'b110,
        sign_extend_double = 3'b111
    } iaae_ext_type;

    typedef enum logic [2:0] {
        IAAE_OP_NONE = 3'b000,
        IAAE_OP_ABS = 3'b001,
        IAAE_OP_ADC = 3'b010,
        add_carry_flags_op = 3'b011,
        IAAE_OP_ADDX = 3'b100
    } iaae_op_type;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } iaae_flags_type;

    // register file read request: first and second source field numbers
    typedef struct packed {
        logic [4:0] first_src_field;
        logic [4:0] second_src_field;
    } iaae_rd_req_type;

    // writeback to a general register or the stack pointer
    typedef struct packed {
        logic valid;
        logic to_sp;
        logic [4:0] dest;
        logic [63:0] data;
        logic flags_we;
        iaae_flags_type flags;
        logic undef;
    } iaae_result_type;
endpackage

// file: core/iaae_exec.sv
// single-cycle execute stage for abs, add with carry and extended-register add
`timescale 1ns/100ps
`default_nettype none
module iaae_exec
    import iaae_pkg::*;
#(
    parameter logic compact_integer_feature = 1'b1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [63:0] first_src_data_in,
    input wire logic [63:0] second_src_data_in,
    input wire logic [63:0] sp_data_in,
    input wire iaae_flags_type flags_in,
    input wire logic data_independent_timing_bit,
    output iaae_rd_req_type rd_req_out,
    output iaae_result_type result_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        iaae_result_type res;
    } iaae_state_type;

    iaae_state_type state_q;
    iaae_state_type state_d;

    function automatic iaae_op_type iaae_decode(input logic [31:0] w);
        iaae_op_type op;
        op = IAAE_OP_NONE;
        if ((w & IAAE_ABS_MASK) == IAAE_ABS_VAL) begin
            op = IAAE_OP_ABS;
        end else if ((w & IAAE_ADC_MASK) == IAAE_ADC_VAL) begin
            op = IAAE_OP_ADC;
        end else if ((w & IAAE_ADC_MASK) == IAAE_ADD_CARRY_FLAGS_OP_VAL) begin
            op = add_carry_flags_op;
        end else if ((w & IAAE_ADDX_MASK) == IAAE_ADDX_VAL) begin
            op = IAAE_OP_ADDX;
        end
        return op;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode

    iaae_op_type op;
    logic width_select_bit;
    logic [4:0] dest_field;
    logic [4:0] first_src_field;
    logic [4:0] second_src_field;
    logic [2:0] extend_shift_amount;
    iaae_ext_type ext_kind;

    always_comb begin
        op = iaae_decode(instr_in);
        width_select_bit = instr_in[IAAE_WIDTH_BIT];
        dest_field = instr_in[IAAE_RD_LO +: 5];
        first_src_field = instr_in[IAAE_RN_LO +: 5];
        second_src_field = instr_in[IAAE_RM_LO +: 5];
        extend_shift_amount = instr_in[IAAE_AMT_LO +: 3];
        ext_kind = iaae_ext_type'(instr_in[IAAE_OPT_LO +: 3]);
    end

    assign rd_req_out.first_src_field = first_src_field;
    assign rd_req_out.second_src_field = second_src_field;

    ////////////////////////////////////////////////////////////////////////
    // datapath: every path is fixed combinational logic, so latency never
    // depends on operand or flag values, timing bit or not

    logic [63:0] opa;
    logic [63:0] opb;
    logic [63:0] ext_val;
    logic [63:0] mvw;
    logic [64:0] sum65;
    logic [32:0] sum33;
    logic [63:0] res;
    logic cin;
    logic undef;
    iaae_flags_type nf;

    always_comb begin
        // zero register for sources unless stack pointer applies
        opa = (first_src_field == IAAE_REG31) ? 64'h0 : first_src_data_in;
        if (op == IAAE_OP_ADDX && first_src_field == IAAE_REG31) begin
            opa = sp_data_in;
        end
        mvw = (second_src_field == IAAE_REG31) ? 64'h0 : second_src_data_in;
        case (ext_kind)
            zero_extend_byte: ext_val = {56'h0, mvw[7:0]};
            zero_extend_half: ext_val = {48'h0, mvw[15:0]};
            zero_extend_word: ext_val = {32'h0, mvw[31:0]};
            zero_extend_double: ext_val = width_select_bit ? mvw : {32'h0, mvw[31:0]};
            sign_extend_byte: ext_val = {{56{mvw[7]}}, mvw[7:0]};
            sign_extend_half: ext_val = {{48{mvw[15]}}, mvw[15:0]};
            sign_extend_word: ext_val = {{32{mvw[31]}}, mvw[31:0]};
            sign_extend_double: ext_val = width_select_bit ? mvw : {{32{mvw[31]}}, mvw[31:0]};
            default: ext_val = 64'h0;
        endcase
        opb = (op == IAAE_OP_ADDX) ? (ext_val << extend_shift_amount) : mvw;
        cin = (op == IAAE_OP_ADC || op == add_carry_flags_op) ? flags_in.c : 1'b0;
        if (op == IAAE_OP_ABS) begin
            // operand a negated if negative; shares the adder
            opb = 64'h0;
            if (width_select_bit ? first_src_data_in[63] : first_src_data_in[31]) begin
                opa = ~opa;
                cin = 1'b1;
            end
        end
        // narrow operands so upper halves never reach the 32-bit result
        if (!width_select_bit) begin
            opa = {32'h0, opa[31:0]};
            opb = {32'h0, opb[31:0]};
        end
        sum65 = {1'b0, opa} + {1'b0, opb} + {64'h0, cin};
        sum33 = {1'b0, opa[31:0]} + {1'b0, opb[31:0]} + {32'h0, cin};
        res = width_select_bit ? sum65[63:0] : {32'h0, sum65[31:0]};
        if (width_select_bit) begin
            nf.n = res[63];
            nf.z = (res == 64'h0);
            nf.c = sum65[64];
            nf.v = (opa[63] == opb[63]) && (res[63] != opa[63]);
        end else begin
            nf.n = sum33[31];
            nf.z = (sum33[31:0] == 32'h0);
            nf.c = sum33[32];
            nf.v = (opa[31] == opb[31]) && (sum33[31] != opa[31]);
        end
        undef = 1'b0;
        if (op == IAAE_OP_ABS && !compact_integer_feature) begin
            undef = 1'b1;
        end
        if (op == IAAE_OP_ADDX && extend_shift_amount > IAAE_MAX_SHIFT) begin
            undef = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result register

    always_comb begin
        state_d = state_q;
        state_d.res.valid = instr_valid_in && (op != IAAE_OP_NONE) && !undef;
        state_d.res.undef = instr_valid_in && undef;
        state_d.res.dest = dest_field;
        state_d.res.to_sp = (op == IAAE_OP_ADDX) && (dest_field == IAAE_REG31);
        state_d.res.data = res;
        state_d.res.flags_we = instr_valid_in && !undef && (op == add_carry_flags_op);
        state_d.res.flags = nf;
        // abs and plain adds leave flags alone; timing bit has no effect here
        if (data_independent_timing_bit && op == IAAE_OP_ABS) begin
            state_d.res.flags_we = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign result_out = state_q.res;
endmodule
`default_nettype wire

// file: verification/iaae_exec_sva.sv
// assertion checker for the add/abs execute block
`timescale 1ns/100ps
`default_nettype none
module iaae_exec_sva
    import iaae_pkg::*;
#(
    parameter logic compact_integer_feature = 1'b1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [63:0] first_src_data_in,
    input wire logic [63:0] second_src_data_in,
    input wire logic [63:0] sp_data_in,
    input wire iaae_flags_type flags_in,
    input wire logic data_independent_timing_bit,
    input wire iaae_rd_req_type rd_req_out,
    input wire iaae_result_type result_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence s_adc; instr_valid_in && (instr_in & IAAE_ADC_MASK) == IAAE_ADC_VAL; endsequence
    sequence s_add_carry_flags_op; instr_valid_in && (instr_in & IAAE_ADC_MASK) == IAAE_ADD_CARRY_FLAGS_OP_VAL; endsequence
    sequence s_abs; instr_valid_in && (instr_in & IAAE_ABS_MASK) == IAAE_ABS_VAL; endsequence
    sequence s_addx; instr_valid_in && (instr_in & IAAE_ADDX_MASK) == IAAE_ADDX_VAL; endsequence
    chk_src_fields: assert property (rd_req_out == {instr_in[9:5], instr_in[20:16]})
        else $error("source fields wrong");
    chk_adc_answer: assert property (s_adc |=> result_out.valid && !result_out.undef && !result_out.flags_we)
        else $error("adc answer wrong");
    chk_adc_sum: assert property (s_adc ##0 (instr_in[31] && instr_in[20:16] != IAAE_REG31 && instr_in[9:5] != IAAE_REG31)
        |=> result_out.data == $past(first_src_data_in) + $past(second_src_data_in) + 64'($past(flags_in.c)))
        else $error("adc sum wrong");
    chk_add_carry_flags_op_flags: assert property (s_add_carry_flags_op |=> result_out.valid && result_out.flags_we)
        else $error("flag write missing");
    chk_upper_zero: assert property (s_adc ##0 !instr_in[31] |=> result_out.data[63:32] == 32'h0)
        else $error("upper half not zero");
    chk_shift_undef: assert property (s_addx ##0 instr_in[12:10] > IAAE_MAX_SHIFT |=> result_out.undef && !result_out.valid)
        else $error("shift undef missing");
    chk_dest_sp: assert property (s_addx ##0 (instr_in[12:10] <= IAAE_MAX_SHIFT && instr_in[4:0] == IAAE_REG31)
        |=> result_out.valid && result_out.to_sp)
        else $error("stack dest missing");
    chk_abs_legal: assert property (s_abs |=> result_out.undef == !compact_integer_feature && !result_out.flags_we)
        else $error("abs legality wrong");
    chk_idle_quiet: assert property (!instr_valid_in |=> !result_out.valid && !result_out.undef)
        else $error("answer without request");
endmodule
`default_nettype wire

// file: verification/iaae_core_model.sv
// register file model standing at the core side of the execute block
`timescale 1ns/100ps
`default_nettype none
module iaae_core_model
    import iaae_pkg::*;
(
    input wire logic mclk_in,
    input wire logic we_in,
    input wire logic [4:0] idx_in,
    input wire logic [63:0] wdata_in,
    input wire iaae_rd_req_type rd_req_in,
    output logic [63:0] first_data_out,
    output logic [63:0] second_data_out
);
    logic [63:0] regs_q [0:31];
    always_ff @(posedge mclk_in) if (we_in) regs_q[idx_in] <= wdata_in;
    // slot 31 holds junk on purpose: the block must zero or redirect it itself
    assign first_data_out = regs_q[rd_req_in.first_src_field];
    assign second_data_out = regs_q[rd_req_in.second_src_field];
endmodule
`default_nettype wire

// file: verification/integer_add_abs_execute_tb.sv
// self-checking testbench for the add/abs execute block
`timescale 1ns/100ps
`default_nettype none
module integer_add_abs_execute_tb;
    import iaae_pkg::*;
    logic mclk_in = 1'b0, rst_in = 1'b1, v = 1'b0, we = 1'b1, dit = 1'b1;
    logic [31:0] w = 32'h0;
    logic [63:0] sp = 64'h7fff_ffff_fff0, wd = 64'h0, a, b, rf [0:31];
    logic [4:0] wi = 5'h0;
    iaae_flags_type fl = 4'h2;
    iaae_rd_req_type rq;
    iaae_result_type ro;
    iaae_result_type ro_nofeat;
    int n_mismatch = 0, total_checks = 0;
    always #2 mclk_in = ~mclk_in;
    iaae_exec dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .instr_valid_in(v), .instr_in(w), .first_src_data_in(a),
        .second_src_data_in(b), .sp_data_in(sp), .flags_in(fl), .data_independent_timing_bit(dit),
        .rd_req_out(rq), .result_out(ro));
    // second copy without the compact integer feature, fed the same words, to reach the abs refusal
    iaae_exec #(.compact_integer_feature(1'b0)) nofeat_u (.mclk_in(mclk_in), .rst_in(rst_in), .instr_valid_in(v),
        .instr_in(w), .first_src_data_in(a), .second_src_data_in(b), .sp_data_in(sp), .flags_in(fl),
        .data_independent_timing_bit(dit), .rd_req_out(), .result_out(ro_nofeat));
    iaae_core_model core_u (.mclk_in(mclk_in), .we_in(we), .idx_in(wi), .wdata_in(wd), .rd_req_in(rq),
        .first_data_out(a), .second_data_out(b));
    // 32-bit sums run in the top half so one carry and overflow formula serves both widths
    function automatic logic [67:0] awc(logic [63:0] x, logic [63:0] y, logic ci, logic w64);
        logic [63:0] p, q;
        logic [64:0] s;
        p = w64 ? x : {x[31:0], 32'h0};
        q = w64 ? y : {y[31:0], 32'h0};
        s = {1'b0, p} + {1'b0, q} + (65'(ci) << (w64 ? 0 : 32));
        return {s[63], s[63:0] == 64'h0, s[64], p[63] == q[63] && s[63] != p[63], w64 ? s[63:0] : {32'h0, s[63:32]}};
    endfunction
    function automatic logic [63:0] ext(logic [63:0] x, logic [2:0] o, logic [2:0] s);
        logic [63:0] e;
        case (o[1:0])
            2'h0: e = o[2] ? 64'(signed'(x[7:0])) : 64'(x[7:0]);
            2'h1: e = o[2] ? 64'(signed'(x[15:0])) : 64'(x[15:0]);
            2'h2: e = o[2] ? 64'(signed'(x[31:0])) : 64'(x[31:0]);
            default: e = x;
        endcase
        return e << s;
    endfunction
    function automatic logic [31:0] enc(logic [31:0] o, logic sf, logic [4:0] m, logic [4:0] n, logic [4:0] d);
        return o | {sf, 10'h0, m, 6'h0, n, d};
    endfunction
    function automatic iaae_result_type ex(logic [67:0] x, logic fw, logic [4:0] d, logic ts);
        return {1'b1, ts, d, x[63:0], fw, x[67:64], 1'b0};
    endfunction
    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // fields the block leaves undefined are copied from the expectation before comparing
    task automatic run(string nm, logic vi, logic [31:0] ins, iaae_result_type e);
        iaae_result_type g;
        v = vi;
        w = ins;
        @(posedge mclk_in) #1;
        g = ro;
        if (!e.flags_we) g.flags = e.flags;
        if (!e.valid) {g.to_sp, g.dest, g.data} = {e.to_sp, e.dest, e.data};
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    initial begin
        for (int i = 0; i < 32; i++) begin
            rf[i] = i == 1 ? 64'h7fff_ffff_ffff_ffff : i == 2 ? 64'hffff_ffff_0000_0001 : {8{8'(i * 37 + 129)}};
            wi = 5'(i);
            wd = rf[i];
            @(posedge mclk_in) #1;
            rst_in = i < 4;
        end
        we = 1'b0;
        run("adc64", 1, enc(IAAE_ADC_VAL, 1, 2, 1, 3), ex(awc(rf[1], rf[2], 1, 1), 0, 3, 0));
        run("adc32", 1, enc(IAAE_ADC_VAL, 0, 31, 2, 4), ex(awc(rf[2], 0, 1, 0), 0, 4, 0));
        fl = 4'h0;
        run("adcs32", 1, enc(IAAE_ADD_CARRY_FLAGS_OP_VAL, 0, 2, 1, 5), ex(awc(rf[1], rf[2], 0, 0), 1, 5, 0));
        run("adcs64", 1, enc(IAAE_ADD_CARRY_FLAGS_OP_VAL, 1, 1, 1, 31), ex(awc(rf[1], rf[1], 0, 1), 1, 31, 0));
        for (int s = 0; s < 2; s++) run("abs", 1, enc(IAAE_ABS_VAL, s[0], 0, 7, 9), ex({4'h0, s[0] ? (rf[7][63] ?
            -rf[7] : rf[7]) : {32'h0, rf[7][31] ? -rf[7][31:0] : rf[7][31:0]}}, 0, 9, 0));
        dit = 1'b0;
        run("abs_nodit", 1, enc(IAAE_ABS_VAL, 1, 0, 7, 9), ex({4'h0, rf[7][63] ? -rf[7] : rf[7]}, 0, 9, 0));
        total_checks++;
        if (ro_nofeat.undef !== 1'b1 || ro_nofeat.valid !== 1'b0) begin
            n_mismatch++;
            $display("FAIL abs_nofeature expected undef=1 valid=0 seen undef=%b valid=%b", ro_nofeat.undef,
                ro_nofeat.valid);
        end
        dit = 1'b1;
        for (int o = 0; o < 8; o++) run("addx", 1, enc(IAAE_ADDX_VAL | 32'(o) << 13 | 32'(o % 5) << 10, o[1], 7, 31, 31),
            ex(awc(sp, ext(rf[7], 3'(o), 3'(o % 5)), 0, o[1]), 0, 31, 1));
        run("addx_zr", 1, enc(IAAE_ADDX_VAL | 32'he000, 1, 31, 1, 2), ex(awc(rf[1], 0, 0, 1), 0, 2, 0));
        for (int s = 5; s < 8; s++) run("shift", 1, enc(IAAE_ADDX_VAL | 32'(s) << 10, 1, 1, 2, 3), 77'h1);
        run("idle", 0, 32'h0, 77'h0);
        run("unknown", 1, 32'h0, 77'h0);
        print_verdict();
    end
    initial begin
        #4000;
        n_mismatch++;
        print_verdict();
    end
endmodule
bind iaae_exec iaae_exec_sva #(.compact_integer_feature(compact_integer_feature)) sva_u (.mclk_in(mclk_in),
    .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in), .first_src_data_in(first_src_data_in),
    .second_src_data_in(second_src_data_in), .sp_data_in(sp_data_in), .flags_in(flags_in),
    .data_independent_timing_bit(data_independent_timing_bit), .rd_req_out(rd_req_out), .result_out(result_out));
`default_nettype wire
